/* common/ctsb_map.vh */
/*
 Register map, field positions, reset values and fixed widths of the
 capture timebase block. Assumes it is included by bare name by the core.
*/
`ifndef CTSB_MAP_VH
`define CTSB_MAP_VH

// Byte addresses on the AHB-Lite slave
`define CTSB_ADDR_CTRL1 8'h00
`define CTSB_ADDR_CTRL2 8'h04
`define CTSB_ADDR_COUNT 8'h08
`define CTSB_ADDR_FIFO 8'h0c
`define CTSB_ADDR_STAT 8'h10
`define CTSB_ADDR_IRQ 8'h14
`define CTSB_ADDR_MASK 8'h18

// Control register two fields
`define CTSB_SYNC_LSB 0
`define CTSB_SYNC_MSB 4
`define CTSB_TRIGGER_STATUS_BIT_BIT 6
`define CTSB_TRIGMODE_BIT 7

// Control register one fields
`define CTSB_EN_BIT 0
`define CTSB_EDGE_LSB 1
`define CTSB_EDGE_MSB 2

// Interrupt status bits
`define CTSB_IRQ_CAPT 0
`define CTSB_IRQ_OVF 1
`define CTSB_IRQ_SYNC 2
`define CTSB_IRQ_FULL 3
`define CTSB_IRQ_WIDTH 4

// Reset values
`define CTSB_CTRL1_RST 3'h0
`define CTSB_CTRL2_RST 8'h00
`define CTSB_MASK_RST 4'h0

// Fixed widths
`define CTSB_CNT_W 16
`define CTSB_FIFO_DEPTH 4
`define CTSB_PTR_W 2
`define CTSB_SRC_COUNT 30

`endif

/* core/ctsb_fifo.v */
/*
 Four-entry capture FIFO holding timebase values.
 Assumes single clock; a push into a full FIFO is dropped.
*/
`timescale 1ns/1ns
`include "ctsb_map.vh"

module ctsb_fifo
(
    input wire clk,
    input wire rst,
    input wire push,
    input wire [`CTSB_CNT_W-1:0] push_data,
    input wire pop,
    output wire [`CTSB_CNT_W-1:0] head,
    output wire empty,
    output wire full
);

reg [`CTSB_CNT_W-1:0] mem [0:`CTSB_FIFO_DEPTH-1];
reg [`CTSB_PTR_W-1:0] wr_ptr;
reg [`CTSB_PTR_W-1:0] rd_ptr;
reg [`CTSB_PTR_W:0] level;
wire do_push;
wire do_pop;

assign empty = (level == 3'h0);
assign full = (level == 3'h4);
assign head = mem[rd_ptr];
assign do_push = push && !full;
assign do_pop = pop && !empty;

always @(posedge clk)
begin
    if (do_push)
    begin
        mem[wr_ptr] <= push_data;
    end
end

always @(posedge clk or posedge rst)
begin
    if (rst)
    begin
        wr_ptr <= 2'h0;
        rd_ptr <= 2'h0;
        level <= 3'h0;
    end
    else
    begin
        if (do_push)
        begin
            wr_ptr <= wr_ptr + 2'h1;
        end
        if (do_pop)
        begin
            rd_ptr <= rd_ptr + 2'h1;
        end
        if (do_push && !do_pop)
        begin
            level <= level + 3'h1;
        end
        else if (do_pop && !do_push)
        begin
            level <= level - 3'h1;
        end
    end
end

endmodule // ctsb_fifo

/* core/ctsb_edge.v */
/*
 Edge detector for the capture input pin and for the selected sync line.
 Assumes inputs already synchronous to the clock.
*/
`timescale 1ns/1ns

module ctsb_edge
(
    input wire clk,
    input wire rst,
    input wire level_in,
    input wire [1:0] edge_mode,
    output wire event_out
);

reg prev;

always @(posedge clk or posedge rst)
begin
    if (rst)
    begin
        prev <= 1'b0;
    end
    else
    begin
        prev <= level_in;
    end
end

// 00 off, 01 rising, 10 falling, 11 both
assign event_out = (edge_mode[0] && level_in && !prev) ||
                   (edge_mode[1] && !level_in && prev);

endmodule // ctsb_edge

/* core/ctsb_top.v */
/*
 Capture timebase with sync and trigger control, capture FIFO, interrupt
 logic and an AHB-Lite register slave.
 Assumes inputs synchronous to CLK_SYS, zero-wait single word transfers,
 and sync sources delivered as levels on SYNC_SRC (bit n-1 is source n).
*/
`timescale 1ns/1ns
`include "ctsb_map.vh"

module ctsb_top
(
    input wire CLK_SYS,
    input wire RST,
    input wire HSEL,
    input wire [31:0] HADDR,
    input wire [1:0] HTRANS,
    input wire HWRITE,
    input wire [2:0] HSIZE,
    input wire [31:0] HWDATA,
    input wire HREADY,
    output reg [31:0] HRDATA,
    output reg HREADYOUT,
    output reg HRESP,
    input wire CAPTURE_INPUT_PIN,
    input wire [`CTSB_SRC_COUNT-1:0] SYNC_SRC,
    output reg IRQ
);

////////////////////////////////////////////////////////////////////////////////
// Registers and bus phase capture

reg [2:0] ctrl1;
reg [4:0] sync_source_select;
reg trigger_mode_select;
reg trigger_status_bit;
reg [`CTSB_IRQ_WIDTH-1:0] irq_stat;
reg [`CTSB_IRQ_WIDTH-1:0] irq_mask;
reg [`CTSB_CNT_W-1:0] capture_timebase_counter;
reg dp_write;
reg [7:0] dp_addr;
reg [31:0] next_rdata;

wire addr_ok;
wire rd_req;
wire enable;
wire capt_event;
wire sync_level;
wire sync_event;
wire [`CTSB_CNT_W-1:0] fifo_head;
wire fifo_empty;
wire fifo_full;
wire fifo_pop;
wire stat_read;
wire sw_trig_mode;
wire hw_trig_mode;
wire sync_mode;
wire counter_run;
wire [`CTSB_IRQ_WIDTH-1:0] irq_events;

// Decoded source line; zero and values above the source count select nothing
function sel_line;
    input [4:0] sel;
    input [`CTSB_SRC_COUNT-1:0] src;
    begin
        if (sel == 5'h00 || sel > 5'h1e)
        begin
            sel_line = 1'b0;
        end
        else
        begin
            sel_line = src[sel - 5'h01];
        end
    end
endfunction

assign addr_ok = HSEL && HREADY && HTRANS[1];
assign rd_req = addr_ok && !HWRITE;
assign enable = ctrl1[`CTSB_EN_BIT];
assign sync_level = sel_line(sync_source_select, SYNC_SRC);
assign sw_trig_mode = (sync_source_select == 5'h00) && trigger_mode_select;
assign hw_trig_mode = (sync_source_select != 5'h00) && trigger_mode_select;
assign sync_mode = (sync_source_select != 5'h00) && !trigger_mode_select;
// In both trigger modes the counter and capture wait for the status bit
assign counter_run = enable && (!trigger_mode_select || trigger_status_bit);
assign fifo_pop = rd_req && (HADDR[7:0] == `CTSB_ADDR_FIFO);
assign stat_read = rd_req && (HADDR[7:0] == `CTSB_ADDR_IRQ);

ctsb_edge u_capt_edge
(
    .clk(CLK_SYS),
    .rst(RST),
    .level_in(CAPTURE_INPUT_PIN),
    .edge_mode(ctrl1[`CTSB_EDGE_MSB:`CTSB_EDGE_LSB]),
    .event_out(capt_event)
);

ctsb_edge u_sync_edge
(
    .clk(CLK_SYS),
    .rst(RST),
    .level_in(sync_level),
    .edge_mode(2'h1),
    .event_out(sync_event)
);

// Capture is gated only by enable and, in trigger modes, by release
ctsb_fifo u_fifo
(
    .clk(CLK_SYS),
    .rst(RST),
    .push(capt_event && counter_run),
    .push_data(capture_timebase_counter),
    .pop(fifo_pop),
    .head(fifo_head),
    .empty(fifo_empty),
    .full(fifo_full)
);

////////////////////////////////////////////////////////////////////////////////
// Timebase counter

always @(posedge CLK_SYS or posedge RST)
begin
    if (RST)
    begin
        capture_timebase_counter <= 16'h0000;
    end
    else if (sync_mode && sync_event && enable)
    begin
        capture_timebase_counter <= 16'h0000;
    end
    else if (counter_run)
    begin
        capture_timebase_counter <= capture_timebase_counter + 16'h0001;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Bus slave and control registers

always @(posedge CLK_SYS or posedge RST)
begin
    if (RST)
    begin
        dp_write <= 1'b0;
        dp_addr <= 8'h00;
        HREADYOUT <= 1'b1;
        HRESP <= 1'b0;
    end
    else
    begin
        dp_write <= addr_ok && HWRITE;
        if (addr_ok)
        begin
            dp_addr <= HADDR[7:0];
        end
        HREADYOUT <= 1'b1;
        HRESP <= 1'b0;
    end
end

always @(posedge CLK_SYS or posedge RST)
begin
    if (RST)
    begin
        ctrl1 <= `CTSB_CTRL1_RST;
        sync_source_select <= 5'h00;
        trigger_mode_select <= 1'b0;
        trigger_status_bit <= 1'b0;
        irq_mask <= `CTSB_MASK_RST;
    end
    else
    begin
        if (dp_write && dp_addr == `CTSB_ADDR_CTRL1)
        begin
            ctrl1 <= HWDATA[2:0];
        end
        if (dp_write && dp_addr == `CTSB_ADDR_MASK)
        begin
            irq_mask <= HWDATA[`CTSB_IRQ_WIDTH-1:0];
        end
        if (dp_write && dp_addr == `CTSB_ADDR_CTRL2)
        begin
            sync_source_select <= HWDATA[`CTSB_SYNC_MSB:`CTSB_SYNC_LSB];
            trigger_mode_select <= HWDATA[`CTSB_TRIGMODE_BIT];
        end
        // Hardware release wins over a software write in the same cycle
        if (hw_trig_mode && sync_event && enable)
        begin
            trigger_status_bit <= 1'b1;
        end
        else if (dp_write && dp_addr == `CTSB_ADDR_CTRL2)
        begin
            trigger_status_bit <= HWDATA[`CTSB_TRIGGER_STATUS_BIT_BIT];
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Interrupt status, cleared by read; a new event wins over the clear

assign irq_events = {fifo_full,
                     hw_trig_mode && sync_event && enable,
                     counter_run && (capture_timebase_counter == 16'hffff),
                     capt_event && counter_run};

always @(posedge CLK_SYS or posedge RST)
begin
    if (RST)
    begin
        irq_stat <= 4'h0;
        IRQ <= 1'b0;
    end
    else
    begin
        irq_stat <= (stat_read ? 4'h0 : irq_stat) | irq_events;
        IRQ <= |(((stat_read ? 4'h0 : irq_stat) | irq_events) & irq_mask);
    end
end

////////////////////////////////////////////////////////////////////////////////
// Read data

always @*
begin
    next_rdata = 32'h00000000;
    if (HADDR[7:0] == `CTSB_ADDR_CTRL1)
    begin
        next_rdata[2:0] = ctrl1;
    end
    else if (HADDR[7:0] == `CTSB_ADDR_CTRL2)
    begin
        next_rdata[`CTSB_SYNC_MSB:`CTSB_SYNC_LSB] = sync_source_select;
        next_rdata[`CTSB_TRIGGER_STATUS_BIT_BIT] = trigger_status_bit;
        next_rdata[`CTSB_TRIGMODE_BIT] = trigger_mode_select;
    end
    else if (HADDR[7:0] == `CTSB_ADDR_COUNT)
    begin
        next_rdata[15:0] = capture_timebase_counter;
    end
    else if (HADDR[7:0] == `CTSB_ADDR_FIFO)
    begin
        next_rdata[15:0] = fifo_head;
    end
    else if (HADDR[7:0] == `CTSB_ADDR_STAT)
    begin
        next_rdata[0] = fifo_empty;
        next_rdata[1] = fifo_full;
        next_rdata[2] = sync_mode;
        next_rdata[3] = hw_trig_mode;
        next_rdata[4] = sw_trig_mode;
        next_rdata[5] = counter_run;
    end
    else if (HADDR[7:0] == `CTSB_ADDR_IRQ)
    begin
        next_rdata[`CTSB_IRQ_WIDTH-1:0] = irq_stat;
    end
    else if (HADDR[7:0] == `CTSB_ADDR_MASK)
    begin
        next_rdata[`CTSB_IRQ_WIDTH-1:0] = irq_mask;
    end
end

// Read data is decoded from the address phase and flopped at its edge, so it stands
// through the zero-wait data phase; a read right behind a write sees the old value
always @(posedge CLK_SYS or posedge RST)
begin
    if (RST)
    begin
        HRDATA <= 32'h00000000;
    end
    else if (rd_req)
    begin
        HRDATA <= next_rdata;
    end
end

endmodule // ctsb_top

/* test/ctsb_checker_assertions.sv */
/* Port checker for the capture timebase block.
   Assumes one AHB-Lite transfer at a time and HREADY tied to HREADYOUT. */
`timescale 1ns/1ns
module ctsb_checker
(
    input wire CLK_SYS,
    input wire RST,
    input wire HSEL,
    input wire [31:0] HADDR,
    input wire [1:0] HTRANS,
    input wire HWRITE,
    input wire [31:0] HWDATA,
    input wire HREADY,
    input wire [31:0] HRDATA,
    input wire HREADYOUT,
    input wire HRESP,
    input wire IRQ
);
    reg ap_rd;
    reg ap_wr;
    reg [7:0] ap_a;
    reg [7:0] c2;
    reg [3:0] msk;
    wire sel_on = c2[4:0] != 5'h00;
    wire [2:0] mode = {!sel_on & c2[7], sel_on & c2[7], sel_on & !c2[7]};
    wire r_st = ap_rd && ap_a == 8'h10;
    wire r_cnt = ap_rd && ap_a == 8'h08;
    wire r_fifo = ap_rd && ap_a == 8'h0c;
    wire r_c2 = ap_rd && ap_a == 8'h04;
    wire r_gap = ap_rd && ap_a > 8'h18;
    wire [5:0] c2_sel = {c2[7], c2[4:0]};
    // Shadow of the control fields; the checks leave status bit 6 out as hardware sets it
    always @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            ap_rd <= 1'b0;
            ap_wr <= 1'b0;
            ap_a <= 8'h00;
            c2 <= 8'h00;
            msk <= 4'h0;
        end
        else
        begin
            ap_rd <= HSEL & HREADY & HTRANS[1] & !HWRITE;
            ap_wr <= HSEL & HREADY & HTRANS[1] & HWRITE;
            ap_a <= HADDR[7:0];
            if (ap_wr && ap_a == 8'h04)
                c2 <= HWDATA[7:0];
            if (ap_wr && ap_a == 8'h18)
                msk <= HWDATA[3:0];
        end
    end
    ////////////////////////////////////////
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    a_ready_high: assert property (HREADYOUT)
        else $error("ready low");
    a_resp_okay: assert property (!HRESP)
        else $error("error response");
    a_mode_decode: assert property (r_st |-> HRDATA[4:2] == $past(mode))
        else $error("mode bits wrong");
    a_count_width: assert property (r_cnt |-> HRDATA[31:16] == 16'h0000)
        else $error("counter wider than 16 bits");
    a_fifo_width: assert property (r_fifo |-> HRDATA[31:16] == 16'h0000)
        else $error("fifo value wider than 16 bits");
    a_sel_readback: assert property (r_c2 |-> {HRDATA[7], HRDATA[4:0]} == $past(c2_sel))
        else $error("select field readback wrong");
    a_gap_zero: assert property (r_gap |-> HRDATA == 32'h0)
        else $error("unmapped read not zero");
    a_irq_masked: assert property ((msk == 4'h0)[*3] |-> !IRQ)
        else $error("interrupt with all masked");
    c_hw_mode: cover property (r_st ##1 HRDATA[3]);
    c_irq: cover property ($rose(IRQ));
    c_pop: cover property (r_fifo);
endmodule // ctsb_checker

bind ctsb_top ctsb_checker u_chk (.CLK_SYS(CLK_SYS), .RST(RST), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .IRQ(IRQ));

/* test/ctsb_far_end.sv */
/* Far side model: capture pin and thirty sync source lines.
   Assumes pulses launched just after a rising edge; lines idle low. */
`timescale 1ns/1ns
module ctsb_far_end
(
    input wire clk,
    output reg pin,
    output reg [29:0] src
);
    initial
    begin
        pin = 1'b0;
        src = 30'h0;
    end
    task pin_pulse;
    begin
        @(posedge clk);
        pin <= 1'b1;
        @(posedge clk);
        pin <= 1'b0;
    end
    endtask
    // Source n sits on bit n-1
    task src_pulse(input integer n);
    begin
        @(posedge clk);
        src[n-1] <= 1'b1;
        @(posedge clk);
        src[n-1] <= 1'b0;
    end
    endtask
endmodule // ctsb_far_end

/* test/capture_timebase_sync_trigger_tb_top.sv */
/* Self-checking bench for the capture timebase block.
   Assumes an AHB-Lite slave; read data is taken at the data-phase ready edge. */
`timescale 1ns/1ns
module capture_timebase_sync_trigger_tb_top;
    reg CLK_SYS;
    reg RST;
    reg HSEL;
    reg HWRITE;
    reg [31:0] HADDR;
    reg [31:0] HWDATA;
    reg [1:0] HTRANS;
    wire [31:0] HRDATA;
    wire HREADYOUT;
    wire HRESP;
    wire IRQ;
    wire pin;
    wire [29:0] src;
    integer miscompares;
    integer n_checks;
    integer cyc;
    integer ts;
    integer t1;
    integer n;
    reg [31:0] q;
    reg [31:0] q2;
    ctsb_top dut (.CLK_SYS(CLK_SYS), .RST(RST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
        .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
        .HREADYOUT(HREADYOUT), .HRESP(HRESP), .CAPTURE_INPUT_PIN(pin), .SYNC_SRC(src),
        .IRQ(IRQ));
    ctsb_far_end u_far (.clk(CLK_SYS), .pin(pin), .src(src));
    initial
    begin
        CLK_SYS = 1'b0;
        forever #25 CLK_SYS = ~CLK_SYS;
    end
    always @(posedge CLK_SYS) cyc <= cyc + 1;
    ////////////////////////////////////////
    task chk(input [31:0] got, input [31:0] exp);
    begin
        n_checks = n_checks + 1;
        if (got !== exp)
        begin
            miscompares = miscompares + 1;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    end
    endtask
    // One single transfer; ts stamps the data-phase edge for counter deltas
    task bus(input w, input [7:0] a, input [31:0] d);
    begin
        @(posedge CLK_SYS);
        HSEL <= 1'b1;
        HTRANS <= 2'b10;
        HWRITE <= w;
        HADDR <= {24'h0, a};
        @(posedge CLK_SYS);
        while (HREADYOUT !== 1'b1) @(posedge CLK_SYS);
        HSEL <= 1'b0;
        HTRANS <= 2'b00;
        HWDATA <= d;
        @(posedge CLK_SYS);
        while (HREADYOUT !== 1'b1) @(posedge CLK_SYS);
        ts = cyc;
        q = HRDATA;
    end
    endtask
    task span(input run);
    begin
        bus(1'b0, 8'h08, 0);
        q2 = q;
        t1 = ts;
        repeat (10) @(posedge CLK_SYS);
        bus(1'b0, 8'h08, 0);
        chk(q - q2, run ? ts - t1 : 0);
    end
    endtask
    ////////////////////////////////////////
    task t_regs;
    begin
        bus(1'b0, 8'h04, 0);
        chk(q, 32'h0);
        bus(1'b1, 8'h1c, 32'hffffffff);
        bus(1'b0, 8'h1c, 0);
        chk(q, 32'h0);
    end
    endtask
    task t_free;
    begin
        bus(1'b1, 8'h00, 32'h1);
        span(1'b1);
        bus(1'b0, 8'h10, 0);
        chk(q & 32'h3c, 32'h20);
    end
    endtask
    task t_sync;
    begin
        bus(1'b1, 8'h00, 32'h3);
        bus(1'b1, 8'h04, 32'h3);
        repeat (40) @(posedge CLK_SYS);
        u_far.src_pulse(4);
        bus(1'b0, 8'h08, 0);
        chk(q > 32'd40, 1);
        u_far.src_pulse(3);
        bus(1'b0, 8'h08, 0);
        chk(q < 32'd16, 1);
        u_far.pin_pulse;
        bus(1'b0, 8'h10, 0);
        chk(q & 32'h3d, 32'h24);
        bus(1'b0, 8'h0c, 0);
    end
    endtask
    task t_fifo;
    begin
        bus(1'b1, 8'h04, 32'h0);
        bus(1'b1, 8'h18, 32'h1);
        repeat (5)
        begin
            u_far.pin_pulse;
            repeat (8) @(posedge CLK_SYS);
        end
        bus(1'b0, 8'h10, 0);
        chk(q & 32'h3, 32'h2);
        chk(IRQ, 1);
        bus(1'b0, 8'h14, 0);
        chk(q & 32'h1, 32'h1);
        @(posedge CLK_SYS);
        chk(IRQ, 0);
        bus(1'b0, 8'h0c, 0);
        q2 = q;
        repeat (3)
        begin
            bus(1'b0, 8'h0c, 0);
            chk(q - q2, 32'd10);
            q2 = q;
        end
        bus(1'b0, 8'h10, 0);
        chk(q & 32'h1, 32'h1);
        bus(1'b1, 8'h18, 32'h0);
        u_far.pin_pulse;
        repeat (3) @(posedge CLK_SYS);
        chk(IRQ, 0);
    end
    endtask
    // Source 30 is the top of the select range
    task t_hw;
    begin
        bus(1'b1, 8'h04, 32'h9e);
        span(1'b0);
        bus(1'b0, 8'h10, 0);
        chk(q & 32'h3c, 32'h08);
        u_far.src_pulse(30);
        repeat (3) @(posedge CLK_SYS);
        bus(1'b0, 8'h04, 0);
        chk(q & 32'hdf, 32'hde);
        span(1'b1);
    end
    endtask
    task t_sw;
    begin
        bus(1'b1, 8'h04, 32'h80);
        span(1'b0);
        bus(1'b0, 8'h10, 0);
        chk(q & 32'h3c, 32'h10);
        bus(1'b1, 8'h04, 32'hc0);
        span(1'b1);
    end
    endtask
    task t_ovf;
    begin
        bus(1'b1, 8'h04, 32'h0);
        bus(1'b1, 8'h18, 32'h2);
        n = 0;
        while (IRQ !== 1'b1 && n < 70000)
        begin
            n = n + 1;
            @(posedge CLK_SYS);
        end
        chk(IRQ, 1);
        bus(1'b0, 8'h08, 0);
        chk(q < 32'd16, 1);
        bus(1'b0, 8'h14, 0);
        chk(q & 32'h2, 32'h2);
        @(posedge CLK_SYS);
        chk(IRQ, 0);
    end
    endtask
    task tally_and_finish;
    begin
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    end
    endtask
    ////////////////////////////////////////
    initial
    begin
        RST = 1'b1;
        HSEL = 1'b0;
        HWRITE = 1'b0;
        HADDR = 32'h0;
        HWDATA = 32'h0;
        HTRANS = 2'b00;
        miscompares = 0;
        n_checks = 0;
        cyc = 0;
        repeat (3) @(posedge CLK_SYS);
        RST <= 1'b0;
        t_regs;
        t_free;
        t_sync;
        t_fifo;
        t_hw;
        t_sw;
        t_ovf;
        tally_and_finish;
    end
    // Overflow alone takes 65536 cycles, so the limit sits well above it
    initial
    begin
        repeat (90000) @(posedge CLK_SYS);
        miscompares = miscompares + 1;
        tally_and_finish;
    end
endmodule // capture_timebase_sync_trigger_tb_top
